// ==== design/hbridge_pkg.sv ====
// Purpose: shared constants for the h-bridge control and protection block
// Assumes: core clock of 250 MHz
// Notes: timing figures are plain defaults; analog thresholds live outside
package hbridge_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_BLANK_NS = 2000;
  localparam int T_FILTER_NS = 1000;
  localparam int T_TRANS_NS = 4000;

  // least times round up, never below one cycle
  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int BLANK_CYC = ns_to_cyc(T_BLANK_NS);
  localparam int FILTER_CYC = ns_to_cyc(T_FILTER_NS);
  localparam int TRANS_CYC = ns_to_cyc(T_TRANS_NS);
  localparam int CNT_W = 12;
  localparam int OL_PULSE_MIN = 5;

  // ----------------------------------------
  // serial commands, top three bits of the input byte
  // ----------------------------------------
  localparam logic [2:0] CMD_RD_DIA = 3'h0;
  localparam logic [2:0] CMD_DIAGNOSIS_RESET_COMMAND = 3'h4;
  localparam logic [2:0] CMD_REVISION_READ_COMMAND = 3'h1;
  localparam logic [2:0] CMD_RD_CTRL = 3'h3;
  localparam logic [2:0] CMD_WR_CTRL = 3'h7;
  localparam logic [2:0] CMD_WR_RD_DIA = 3'h6;

  // ----------------------------------------
  // register fields and reset values
  // ----------------------------------------
  localparam int DIA_EN_BIT = 7;
  localparam int DIA_OT_BIT = 6;
  localparam int DIA_TV_BIT = 5;
  localparam int DIA_CL_BIT = 4;
  localparam int CTRL_OPEN_LOAD_DISCONNECT_BIT = 4;
  localparam logic [7:0] DIA_RESET = 8'hDF;
  localparam logic [4:0] CTRL_RESET = 5'h00;
  localparam logic [3:0] DIA_CODE_OK = 4'hF;
  localparam logic [3:0] DIA_CODE_OL = 4'hC;
  localparam logic [3:0] DIA_CODE_UV = 4'h3;

  // short latch index: a low bit in the code marks that fault
  localparam int SC_GND_A = 0;
  localparam int SC_BAT_A = 1;
  localparam int SC_GND_B = 2;
  localparam int SC_BAT_B = 3;

  // gate vector {high_a, low_a, high_b, low_b}
  localparam logic [3:0] GATE_OFF = 4'h0;
  localparam logic [3:0] GATE_FWD = 4'h9;
  localparam logic [3:0] GATE_REV = 4'h6;
  localparam logic [3:0] GATE_FW_A = 4'h8;
  localparam logic [3:0] GATE_FW_B = 4'h2;

  typedef enum logic [2:0] {
    ST_RUN  = 3'b001,
    ST_OFF  = 3'b010,
    ST_TRIP = 3'b100
  } bridge_state_t;

endpackage

// ==== design/spi_link_if.sv ====
// Purpose: carries the byte pair and fault level between core and shifter
// Assumes: tx_byte only changes while chip select is high
// Notes: rx_byte is read by the core only after chip select has risen
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  logic fault_flag;
  modport core (output tx_byte, output fault_flag, input rx_byte);
  modport shifter (input tx_byte, input fault_flag, output rx_byte);
endinterface
`default_nettype wire

// ==== design/spi_shifter.sv ====
// Purpose: serial shift engine running on the master's serial clock
// Assumes: serial clock idles low and only moves while chip select is low
// Notes: chip select high clears the frame state without any clock edge
`timescale 1ns/1ps
`default_nettype none
module spi_shifter (
  // serial pins
  input wire logic sck_i,
  input wire logic csn_i,
  input wire logic si_i,
  output logic so_o,
  // core side
  spi_link_if.shifter link
);

  logic [7:0] rx_ff;
  logic [6:0] tx_sh_ff;
  logic so_ff;
  logic started_ff;

  // ----------------------------------------
  // receive: sample on falling edge, msb first
  // ----------------------------------------
  always_ff @(negedge sck_i) begin
    if (!csn_i) begin
      rx_ff <= {rx_ff[6:0], si_i};
    end
  end
  assign link.rx_byte = rx_ff;

  // ----------------------------------------
  // transmit: update on rising edge; later bits pass input on for chaining
  // ----------------------------------------
  always_ff @(posedge sck_i or posedge csn_i) begin
    if (csn_i) begin
      started_ff <= 1'b0;
      tx_sh_ff <= 7'h00;
      so_ff <= 1'b0;
    end else if (!started_ff) begin
      started_ff <= 1'b1;
      so_ff <= link.tx_byte[7];
      tx_sh_ff <= link.tx_byte[6:0];
    end else begin
      so_ff <= tx_sh_ff[6];
      tx_sh_ff <= {tx_sh_ff[5:0], rx_ff[0]};
    end
  end

  // before the first rising edge the pin shows the flag, without a clock
  assign so_o = started_ff ? so_ff : (link.fault_flag | si_i);

endmodule
`default_nettype wire

// ==== design/hbridge_ctrl.sv ====
// Purpose: control, protection and serial diagnosis of one h-bridge
// Assumes: comparators outside deliver digital levels; master drives clock
// Notes: serial output path is combinational so the flag needs no clock
// What this block does
// - disable high turns every switch off
// - pulse and direction select the four output states
// - high-side overcurrent past blanking cuts opposite low
// - resume table; space limiting transitions by minimum time
// - filtered high-side short trips both outputs, reports ground
// - short trip held until disable toggle, sleep, reset
// - low-side short reported as short to battery
// - load short caught by whichever detector fires first
// - overtemperature latches off until below restart level
// - undervoltage turns off, resumes by itself
// - disabled: sources on, out_a high reports open load
// - disconnect bit removes sources, mutes open load
// - on-state open load after five missed freewheels
// - open load indication follows the condition, unlatched
// - serial supply low means sleep with outputs off
// - chip select low pulse frames; clocks not counted
// - eight bits msb first; sample fall, shift rise
// - flag shown on output before first rising clock
// - shown flag is ORed with serial input
// - clock and select held low show flag always
// - top three bits command; revision first; control commands answer control; else diagnosis
// - code all ones clean; shorts latched, others not
`timescale 1ns/1ps
`default_nettype none
module hbridge_ctrl
  import hbridge_pkg::*;
#(
  parameter logic [7:0] REVISION = 8'hA5 // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // bridge control pins
  input wire logic bridge_disable_in_i,
  input wire logic pwm_i,
  input wire logic dir_i,
  input wire logic serial_output_supply_i,
  // analog comparators
  input wire logic over_temperature_i,
  input wire logic below_restart_temp_i,
  input wire logic undervoltage_i,
  input wire logic high_a_over_limit_i,
  input wire logic high_b_over_limit_i,
  input wire logic high_a_short_i,
  input wire logic high_b_short_i,
  input wire logic low_a_short_i,
  input wire logic low_b_short_i,
  input wire logic out_a_high_i,
  input wire logic freewheel_seen_i,
  // switch and source drives
  output logic high_switch_a_o,
  output logic low_switch_a_o,
  output logic high_switch_b_o,
  output logic low_switch_b_o,
  output logic pullup_a_o,
  output logic pulldown_b_o,
  // serial port
  input wire logic spi_sck_i,
  input wire logic spi_csn_i,
  input wire logic spi_si_i,
  output logic spi_so_o,
  output logic spi_so_oe_o
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  localparam int NSYNC = 16;
  // reset to the pins' idle levels (select high, serial supply awake), so
  // no false frame end reloads the response or the control bits after reset
  localparam logic [NSYNC-1:0] SYNC_IDLE = 16'h8008;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_ff;
  logic [NSYNC-1:0] s2_ff;
  logic [NSYNC-1:0] prev_ff;

  assign raw_in = {spi_csn_i, freewheel_seen_i, out_a_high_i, low_b_short_i,
                   low_a_short_i, high_b_short_i, high_a_short_i,
                   high_b_over_limit_i, high_a_over_limit_i, undervoltage_i,
                   below_restart_temp_i, over_temperature_i,
                   serial_output_supply_i, dir_i, pwm_i, bridge_disable_in_i};

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s1_ff <= SYNC_IDLE;
      s2_ff <= SYNC_IDLE;
      prev_ff <= SYNC_IDLE;
    end else begin
      s1_ff <= raw_in;
      s2_ff <= s1_ff;
      prev_ff <= s2_ff;
    end
  end

  wire dis_s = s2_ff[0];
  wire pwm_s = s2_ff[1];
  wire dir_s = s2_ff[2];
  wire vso_s = s2_ff[3];
  wire ot_s = s2_ff[4];
  wire cool_s = s2_ff[5];
  wire uv_s = s2_ff[6];
  wire [1:0] lim_in = s2_ff[8:7];
  // index order follows SC_GND_A, SC_BAT_A, SC_GND_B, SC_BAT_B
  wire [3:0] sc_in = {s2_ff[12], s2_ff[10], s2_ff[11], s2_ff[9]};
  wire ola_s = s2_ff[13];
  wire fw_s = s2_ff[14];
  wire csn_s = s2_ff[15];
  wire dis_fall = prev_ff[0] & ~dis_s;
  wire pwm_rise = ~prev_ff[1] & pwm_s;
  wire frame_end = ~prev_ff[15] & csn_s;
  wire sleep_s = ~vso_s;

  // ----------------------------------------
  // serial command decode
  // ----------------------------------------
  spi_link_if link ();
  logic [4:0] ctrl_ff;
  logic [7:0] resp_ff;
  logic [7:0] diag_ff;
  wire [2:0] cmd = link.rx_byte[7:5];
  wire cmd_wr = frame_end & ((cmd == CMD_WR_CTRL) | (cmd == CMD_WR_RD_DIA));
  wire cmd_res = frame_end & (cmd == CMD_DIAGNOSIS_RESET_COMMAND);
  wire open_load_disconnect = ctrl_ff[CTRL_OPEN_LOAD_DISCONNECT_BIT];
  logic [7:0] nxt_resp;

  always_comb begin
    case (cmd)
      CMD_REVISION_READ_COMMAND: nxt_resp = REVISION;
      CMD_RD_CTRL: nxt_resp = {CMD_RD_CTRL, ctrl_ff};
      CMD_WR_CTRL: nxt_resp = {CMD_RD_CTRL, link.rx_byte[4:0]};
      default: nxt_resp = diag_ff;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl_ff <= CTRL_RESET;
      resp_ff <= REVISION;
    end else begin
      if (cmd_wr) begin
        ctrl_ff <= link.rx_byte[4:0];
      end
      if (frame_end) begin
        resp_ff <= nxt_resp;
      end
    end
  end

  // ----------------------------------------
  // short detection and latches
  // ----------------------------------------
  logic [CNT_W-1:0] sc_cnt_ff [4];
  logic [3:0] sc_lat_ff;
  logic [3:0] sc_hit;
  wire sc_clr = dis_fall | sleep_s | cmd_res;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sc_hit[i] = sc_in[i] && (sc_cnt_ff[i] == CNT_W'(FILTER_CYC - 1));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 4; i++) begin
        sc_cnt_ff[i] <= '0;
      end
      sc_lat_ff <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        // each detector runs alone, so the first to qualify trips
        sc_cnt_ff[i] <= (sc_in[i] && !sc_hit[i]) ? sc_cnt_ff[i] + 1'b1 : '0;
      end
      // a new trip wins over a clear in the same cycle
      sc_lat_ff <= (sc_lat_ff & ~{4{sc_clr}}) | sc_hit;
    end
  end

  // ----------------------------------------
  // overtemperature latch
  // ----------------------------------------
  logic ot_lat_ff;
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ot_lat_ff <= 1'b0;
    end else begin
      ot_lat_ff <= ot_s | (ot_lat_ff & ~cool_s);
    end
  end

  // ----------------------------------------
  // chopper current limit
  // ----------------------------------------
  logic [CNT_W-1:0] lim_cnt_ff [2];
  logic [1:0] lim_act_ff;
  logic [CNT_W-1:0] trans_cnt_ff;
  logic [1:0] lim_want;
  wire trans_ok = (trans_cnt_ff == '0);
  wire lim_change = trans_ok && (lim_want != lim_act_ff);

  always_comb begin
    for (int i = 0; i < 2; i++) begin
      lim_want[i] = lim_in[i] && (lim_cnt_ff[i] >= CNT_W'(BLANK_CYC));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      lim_cnt_ff[0] <= '0;
      lim_cnt_ff[1] <= '0;
      lim_act_ff <= 2'h0;
      trans_cnt_ff <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (!lim_in[i]) begin
          lim_cnt_ff[i] <= '0;
        end else if (!lim_want[i]) begin
          lim_cnt_ff[i] <= lim_cnt_ff[i] + 1'b1;
        end
      end
      // low-inductance loads would chatter without this spacing
      if (lim_change) begin
        lim_act_ff <= lim_want;
        trans_cnt_ff <= CNT_W'(TRANS_CYC - 1);
      end else if (!trans_ok) begin
        trans_cnt_ff <= trans_cnt_ff - 1'b1;
      end
    end
  end

  // ----------------------------------------
  // bridge state
  // ----------------------------------------
  bridge_state_t state_ff;
  bridge_state_t nxt_state;
  wire trip_now = (|sc_lat_ff) | ot_lat_ff;
  wire off_now = dis_s | sleep_s | uv_s;

  always_comb begin
    case (state_ff)
      ST_RUN, ST_OFF, ST_TRIP: begin
        if (trip_now) begin
          nxt_state = ST_TRIP;
        end else if (off_now) begin
          nxt_state = ST_OFF;
        end else begin
          nxt_state = ST_RUN;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  // ----------------------------------------
  // switch drive
  // ----------------------------------------
  logic [3:0] gate_ff;
  logic [3:0] tt_gate;
  logic [3:0] nxt_gate;

  always_comb begin
    case ({pwm_s, dir_s})
      2'b11: tt_gate = GATE_FWD;
      2'b10: tt_gate = GATE_REV;
      2'b01: tt_gate = GATE_FW_A;
      default: tt_gate = GATE_FW_B;
    endcase
  end

  // limiting on one high side drops the opposite low side
  assign nxt_gate = (trip_now | off_now) ? GATE_OFF :
                    (tt_gate & ~{1'b0, lim_act_ff[1], 1'b0, lim_act_ff[0]});

  wire src_on = dis_s & ~open_load_disconnect;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_ff <= ST_OFF;
      gate_ff <= GATE_OFF;
      pullup_a_o <= 1'b0;
      pulldown_b_o <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      gate_ff <= nxt_gate;
      pullup_a_o <= src_on;
      pulldown_b_o <= src_on;
    end
  end

  assign high_switch_a_o = gate_ff[3];
  assign low_switch_a_o = gate_ff[2];
  assign high_switch_b_o = gate_ff[1];
  assign low_switch_b_o = gate_ff[0];

  // ----------------------------------------
  // open load, off and on state
  // ----------------------------------------
  logic fw_got_ff;
  logic [2:0] ol_cnt_ff;
  wire ol_on = (ol_cnt_ff >= 3'(OL_PULSE_MIN));
  wire ol_report = ~open_load_disconnect & ((dis_s & ola_s) | (~dis_s & ol_on));

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      fw_got_ff <= 1'b0;
      ol_cnt_ff <= 3'h0;
    end else begin
      if (pwm_rise) begin
        fw_got_ff <= 1'b0;
      end else if (!pwm_s && fw_s) begin
        fw_got_ff <= 1'b1;
      end
      if (state_ff != ST_RUN) begin
        ol_cnt_ff <= 3'h0;
      end else if (pwm_rise) begin
        if (fw_got_ff) begin
          ol_cnt_ff <= 3'h0;
        end else if (!ol_on) begin
          ol_cnt_ff <= ol_cnt_ff + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // diagnosis register and fault flag
  // ----------------------------------------
  logic [3:0] nxt_code;
  logic fault_ff;
  assign nxt_code = (|sc_lat_ff) ? ~sc_lat_ff :
                    uv_s ? DIA_CODE_UV :
                    ol_report ? DIA_CODE_OL : DIA_CODE_OK;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      diag_ff <= DIA_RESET;
      fault_ff <= 1'b0;
    end else begin
      diag_ff[DIA_EN_BIT] <= ~dis_s;
      diag_ff[DIA_OT_BIT] <= ~ot_lat_ff;
      diag_ff[DIA_TV_BIT] <= 1'b0;
      diag_ff[DIA_CL_BIT] <= ~(|lim_act_ff);
      diag_ff[3:0] <= nxt_code;
      fault_ff <= trip_now | off_now;
    end
  end

  assign link.tx_byte = resp_ff;
  assign link.fault_flag = fault_ff;

  // the output must answer chip select without a clock edge
  spi_shifter u_shifter (
    .sck_i (spi_sck_i),
    .csn_i (spi_csn_i),
    .si_i  (spi_si_i),
    .so_o  (spi_so_o),
    .link  (link)
  );
  assign spi_so_oe_o = ~spi_csn_i;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence short_qualified;
    sc_hit[SC_GND_A] ##1 sc_lat_ff[SC_GND_A];
  endsequence

  chk_disable_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    dis_s |=> (gate_ff == GATE_OFF)) else $error("switch on while disabled");
  chk_truth_fwd: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!off_now && !trip_now && pwm_s && dir_s && lim_act_ff == 2'h0)
    |=> (gate_ff == GATE_FWD)) else $error("forward state wrong");
  chk_limit_cut: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    lim_act_ff[0] |=> !gate_ff[0]) else $error("low side b on during limit");
  chk_trans_space: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !trans_ok |=> $stable(lim_act_ff) || $past(trans_cnt_ff) == 12'h0)
    else $error("limit changed too soon");
  chk_short_trip: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    short_qualified |=> (gate_ff == GATE_OFF) && (diag_ff[SC_GND_A] == 1'b0))
    else $error("short not tripped");
  chk_short_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (sc_lat_ff[SC_BAT_B] && !sc_clr) |=> sc_lat_ff[SC_BAT_B])
    else $error("short latch dropped");
  chk_ot_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ot_lat_ff && !cool_s) |=> ot_lat_ff ##1 (gate_ff == GATE_OFF))
    else $error("overtemperature latch dropped");
  chk_uv_off: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    uv_s |=> (gate_ff == GATE_OFF) && (state_ff != ST_RUN))
    else $error("undervoltage not off");
  chk_ol_count: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (ol_cnt_ff < 3'(OL_PULSE_MIN) && !dis_s) |=> diag_ff[3:0] != DIA_CODE_OL)
    else $error("open load too early");
  chk_open_load_disconnect_mute: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    open_load_disconnect |=> (diag_ff[3:0] != DIA_CODE_OL) && !pullup_a_o)
    else $error("open load not muted");

endmodule
`default_nettype wire

// ==== sim/spi_master_model.sv ====
// Purpose: serial master model for the h-bridge block
// Assumes: link clock of 48 ns period, stopped between frames
// Notes: frame timing is free-running, not tied to the core clock
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  // serial pins toward the device
  output logic sck_o,
  output logic csn_o,
  output logic si_o,
  input wire logic so_i
);
  localparam time HALF = 24ns;

  initial begin
    sck_o = 1'b0;
    csn_o = 1'b1;
    si_o = 1'b1;
  end

  // ----------------------------------------
  // one chip select low pulse carries one byte
  // ----------------------------------------
  task automatic frame(input logic [7:0] tx, output logic [7:0] rx);
    csn_o = 1'b0;
    // data moves on the rising edge so it never races the falling sample
    for (int i = 7; i >= 0; i--) begin
      #HALF sck_o = 1'b1;
      si_o = tx[i];
      #HALF rx[i] = so_i;
      sck_o = 1'b0;
    end
    #HALF csn_o = 1'b1;
    // released line must not keep showing the last bit
    si_o = ~si_o;
    #100;
  endtask

  // select held low with the clock still: the flag ORed with s shows
  task automatic peek(input logic s, output logic f);
    csn_o = 1'b0;
    si_o = s;
    #10 f = so_i;
    csn_o = 1'b1;
    si_o = ~s;
    #100;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// Purpose: self-checking bench for the h-bridge control block
// Assumes: core clock 4 ns; inputs driven 1 ns after the rising edge
// Notes: each diagnosis read is two frames since answers arrive one frame late
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hbridge_pkg::*;
  localparam logic [7:0] REV = 8'h3C; // arbitrary value
  logic clk_i = 1'b0;
  logic rst_n = 1'b0;
  logic disable_in = 1'b0;
  logic pwm = 1'b0;
  logic dir = 1'b0;
  logic so_supply = 1'b1;
  logic hot = 1'b0;
  logic cool = 1'b0;
  logic uvolt = 1'b0;
  logic lim_a = 1'b0;
  logic lim_b = 1'b0;
  logic [3:0] shorts = 4'h0;
  logic open_a = 1'b0;
  logic fwheel = 1'b0;
  logic ha, la, hb, lb, pu, pd, sck, csn, si, so, so_en;
  wire [3:0] gates = {ha, la, hb, lb};
  int n_errors = 0;
  int checks = 0;
  int cyc = 0;
  logic [7:0] rx;
  logic f;

  hbridge_ctrl #(.REVISION(REV)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n), .bridge_disable_in_i(disable_in), .pwm_i(pwm),
    .dir_i(dir), .serial_output_supply_i(so_supply), .over_temperature_i(hot),
    .below_restart_temp_i(cool), .undervoltage_i(uvolt), .high_a_over_limit_i(lim_a),
    .high_b_over_limit_i(lim_b), .high_a_short_i(shorts[SC_GND_A]),
    .high_b_short_i(shorts[SC_GND_B]), .low_a_short_i(shorts[SC_BAT_A]),
    .low_b_short_i(shorts[SC_BAT_B]), .out_a_high_i(open_a), .freewheel_seen_i(fwheel),
    .high_switch_a_o(ha), .low_switch_a_o(la), .high_switch_b_o(hb), .low_switch_b_o(lb),
    .pullup_a_o(pu), .pulldown_b_o(pd), .spi_sck_i(sck), .spi_csn_i(csn),
    .spi_si_i(si), .spi_so_o(so), .spi_so_oe_o(so_en));

  spi_master_model master (.sck_o(sck), .csn_o(csn), .si_o(si), .so_i(so));

  initial begin
    forever #2 clk_i = ~clk_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic bad(input string msg);
    n_errors++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) bad(msg);
  endtask

  task automatic chk_gate(input logic [3:0] exp, input string msg);
    checks++;
    if (gates !== exp) bad(msg);
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checks++;
    if (got !== exp) bad(msg);
  endtask

  task automatic cmd(input logic [7:0] tx);
    master.frame(tx, rx);
    step(6);
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_table();
    logic [3:0] tbl [4] = '{GATE_FW_B, GATE_FW_A, GATE_REV, GATE_FWD};
    cmd(8'h00);
    chk_byte(rx, REV, "first answer");
    cmd(8'h20);
    chk_byte(rx, DIA_RESET, "clean diagnosis");
    cmd(8'h00);
    chk_byte(rx, REV, "revision command");
    for (int i = 0; i < 4; i++) begin
      {pwm, dir} = i[1:0];
      step(5);
      chk_gate(tbl[i], "truth table");
    end
    disable_in = 1'b1;
    step(5);
    chk_gate(GATE_OFF, "disable");
    chk_bit(pu & pd, 1'b1, "sources on");
    master.peek(1'b0, f);
    chk_bit(f, 1'b1, "flag when disabled");
    disable_in = 1'b0;
    step(5);
    master.peek(1'b0, f);
    chk_bit(f, 1'b0, "flag clean");
    master.peek(1'b1, f);
    chk_bit(f, 1'b1, "flag or serial in");
    chk_bit(so_en, 1'b0, "output released");
    chk_gate(GATE_FWD, "enabled again");
    $display("test table done");
  endtask

  task automatic t_open();
    disable_in = 1'b1;
    open_a = 1'b1;
    step(5);
    cmd(8'h00);
    cmd(8'h00);
    chk_byte(rx, 8'h5C, "open load off");
    open_a = 1'b0;
    cmd(8'h00);
    cmd(8'h00);
    chk_byte(rx, 8'h5F, "open load gone");
    open_a = 1'b1;
    cmd(8'hF0);
    chk_bit(pu, 1'b0, "sources removed");
    cmd(8'h00);
    chk_byte(rx, 8'h70, "control echo");
    cmd(8'h00);
    chk_byte(rx, 8'h5F, "open load muted");
    cmd(8'hE0);
    cmd(8'h00);
    open_a = 1'b0;
    disable_in = 1'b0;
    step(5);
    $display("test open load done");
  endtask

  task automatic t_short();
    for (int k = 0; k < 4; k++) begin
      shorts = 4'h1 << k;
      step(FILTER_CYC + 5);
      chk_gate(GATE_OFF, "short trip");
      shorts = 4'h0;
      step(10);
      chk_gate(GATE_OFF, "trip latched");
      cmd(8'h00);
      cmd(8'h80);
      chk_byte(rx, {4'hD, ~(4'h1 << k)}, "short code");
      chk_gate(GATE_FWD, "cleared by command");
    end
    shorts = 4'h1;
    step(FILTER_CYC + 5);
    shorts = 4'h0;
    so_supply = 1'b0;
    step(5);
    chk_gate(GATE_OFF, "sleep");
    so_supply = 1'b1;
    step(5);
    chk_gate(GATE_FWD, "cleared by sleep");
    $display("test short done");
  endtask

  task automatic t_supply();
    uvolt = 1'b1;
    step(5);
    chk_gate(GATE_OFF, "undervoltage");
    cmd(8'h00);
    cmd(8'h00);
    chk_byte(rx, 8'hD3, "undervoltage code");
    uvolt = 1'b0;
    step(5);
    chk_gate(GATE_FWD, "undervoltage resume");
    hot = 1'b1;
    step(5);
    chk_gate(GATE_OFF, "overheat");
    hot = 1'b0;
    step(5);
    chk_gate(GATE_OFF, "overheat latched");
    cool = 1'b1;
    step(5);
    chk_gate(GATE_FWD, "overheat restart");
    cool = 1'b0;
    $display("test supply done");
  endtask

  task automatic t_limit();
    lim_a = 1'b1;
    step(BLANK_CYC + 5);
    chk_gate(GATE_FW_A, "chopper cut");
    cmd(8'h00);
    cmd(8'h00);
    chk_byte(rx, 8'hCF, "limit bit");
    lim_a = 1'b0;
    step(5);
    chk_gate(GATE_FW_A, "minimum spacing");
    step(TRANS_CYC + 10);
    chk_gate(GATE_FWD, "chopper release");
    $display("test limit done");
  endtask

  task automatic t_ol_run();
    for (int i = 0; i < 5; i++) begin
      pwm = 1'b0;
      step(5);
      pwm = 1'b1;
      step(5);
      if (i == 3) begin
        cmd(8'h00);
        cmd(8'h00);
        chk_byte(rx, 8'hDF, "open load too early");
      end
    end
    cmd(8'h00);
    cmd(8'h00);
    chk_byte(rx, 8'hDC, "open load running");
    pwm = 1'b0;
    fwheel = 1'b1;
    step(5);
    fwheel = 1'b0;
    pwm = 1'b1;
    step(5);
    cmd(8'h00);
    cmd(8'h00);
    chk_byte(rx, 8'hDF, "open load cleared");
    $display("test open load run done");
  endtask

  initial begin
    step(2);
    rst_n = 1'b1;
    step(4);
    t_table();
    t_open();
    t_short();
    t_supply();
    t_limit();
    t_ol_run();
    close_out();
  end

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      bad("timeout");
      close_out();
    end
  end
endmodule
`default_nettype wire
